// File: logic/cls_sequencer.sv
`timescale 1ns/1ps
`include "cls_map.svh"
// Summary of operation
// - power-on reset holds status, done low
// - scheme select picks power-on delay length
// - user I/O tristated until user, pulled up only after power-on reset
// - reset while request low, release on rise
// - released status starts configuration stage
// - one data word per data clock
// - release done after all data loaded
// - request low resets, pulls lines low
// - reconfigure only after request high again
// - frame error pulls status low, done low
// - auto restart releases status within 230 us
// - init clock internal, or user clock option
// - internal clock needs no external pulses
// - count 3192 init cycles before user mode
// - user clock init waits indefinitely
// - init output low after first frame option
// - release init output entering user mode
// - user mode drops pull-ups, design drives I/O
module cls_sequencer #(
    parameter int DATA_W       = 8,
    parameter int POR_STD_CYC  = `CLS_POR_STD_CYC,
    parameter int RESTART_CYC  = `CLS_RESTART_CYC,
    parameter int INIT_CYCLES  = `CLS_INIT_CYCLES,
    parameter int IMAGE_WORDS  = 64
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              config_data_clock,
    input  wire logic              user_startup_clock,
    input  wire logic              config_request_n,
    input  wire logic [3:0]        scheme_select,
    input  wire logic [DATA_W-1:0] config_data,
    input  wire logic              frame_error,
    output cls_pkg::cls_pins_t     pins,
    output logic                   user_io_tristate,
    output logic                   user_io_pullup,
    output logic                   user_mode
);
    import cls_pkg::*;

    // ------------------------------------------------------------
    // data clock domain: capture and word count
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       words;
        logic [DATA_W-1:0] first;
        logic              got_first;
        logic              first_tgl;
        logic              full_tgl;
        logic [1:0]        run_sync;
        logic [2:0]        start_sync;
    } cls_link_t;

    cls_link_t lk;
    cls_link_t next_lk;
    logic      load_run;
    logic      start_tgl;

    // the link clock stops between frames, so a new frame is marked by a token
    always_comb begin
        next_lk = lk;
        next_lk.run_sync   = {lk.run_sync[0], load_run};
        next_lk.start_sync = {lk.start_sync[1:0], start_tgl};
        if (!lk.run_sync[1] || (lk.start_sync[2] ^ lk.start_sync[1])) begin
            next_lk.words     = 32'h0;
            next_lk.got_first = 1'b0;
        end else if (lk.words < 32'(IMAGE_WORDS)) begin
            next_lk.words = lk.words + 32'h1;
            if (!lk.got_first) begin
                next_lk.first     = config_data;
                next_lk.got_first = 1'b1;
                next_lk.first_tgl = ~lk.first_tgl;
            end
            if (lk.words == 32'(IMAGE_WORDS - 1))
                next_lk.full_tgl = ~lk.full_tgl;
        end
    end

    // link clock is idle during system reset, so reset acts without it
    always_ff @(posedge config_data_clock or posedge sys_rst) begin
        if (sys_rst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // ------------------------------------------------------------
    // user start-up clock domain: init counter when selected
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  run_sync;
        logic [15:0] cnt;
        logic        done_tgl;
    } cls_uclk_t;

    cls_uclk_t uk;
    cls_uclk_t next_uk;
    logic      uinit_run;

    always_comb begin
        next_uk = uk;
        next_uk.run_sync = {uk.run_sync[0], uinit_run};
        if (!uk.run_sync[1]) begin
            next_uk.cnt = 16'h0;
        end else if (uk.cnt < 16'(INIT_CYCLES)) begin
            next_uk.cnt = uk.cnt + 16'h1;
            if (uk.cnt == 16'(INIT_CYCLES - 1))
                next_uk.done_tgl = ~uk.done_tgl;
        end
    end

    always_ff @(posedge user_startup_clock or posedge sys_rst) begin
        if (sys_rst) begin
            uk <= '0;
        end else begin
            uk <= next_uk;
        end
    end

    // ------------------------------------------------------------
    // system domain sequencer
    // ------------------------------------------------------------
    typedef struct packed {
        cls_state_t  state;
        logic [1:0]  req_sync;
        logic [2:0]  full_sync;
        logic [2:0]  udone_sync;
        logic [3:0]  sel_sync0;
        logic [3:0]  sel_sync;
        logic [1:0]  err_sync;
        logic [31:0] cnt;
        logic        opt_init;
        logic        opt_auto;
        logic        opt_user;
        logic        first_sync0;
        logic        first_sync;
        logic        first_seen;
        logic        start_tgl;
        logic        dlock;
    } cls_sys_t;

    cls_sys_t s;
    cls_sys_t next_s;
    logic     req_n;
    logic     full_evt;
    logic     udone_evt;
    logic     por_fast;
    logic [31:0] por_len;

    assign req_n     = s.req_sync[1];
    assign full_evt  = s.full_sync[2] ^ s.full_sync[1];
    assign udone_evt = s.udone_sync[2] ^ s.udone_sync[1];
    assign load_run  = (s.state == CLS_CONFIG);
    assign start_tgl = s.start_tgl;
    assign uinit_run = (s.state == CLS_INIT) && s.opt_user;

    // fast power-on delay codes; everything else is the standard delay
    always_comb begin
        case (s.sel_sync)
            4'hd, 4'hb, 4'hc, 4'he, 4'h3, 4'h4: por_fast = 1'b1;
            default:                            por_fast = 1'b0;
        endcase
        por_len = por_fast ? 32'(`CLS_POR_FAST_CYC) : 32'(POR_STD_CYC);
    end

    always_comb begin
        next_s = s;
        next_s.req_sync   = {s.req_sync[0], config_request_n};
        next_s.full_sync  = {s.full_sync[1:0], lk.full_tgl};
        next_s.udone_sync = {s.udone_sync[1:0], uk.done_tgl};
        next_s.sel_sync0  = scheme_select;
        next_s.sel_sync   = s.sel_sync0;
        next_s.err_sync   = {s.err_sync[0], frame_error};
        next_s.first_sync0 = lk.first_tgl;
        next_s.first_sync  = s.first_sync0;
        next_s.first_seen  = s.first_sync;
        next_s.cnt = s.cnt + 32'h1;
        case (s.state)
            CLS_POR: begin
                if (s.cnt >= por_len) begin
                    next_s.state = CLS_RESET;
                    next_s.cnt   = 32'h0;
                end
            end
            CLS_RESET: begin
                next_s.opt_init = 1'b0;
                next_s.dlock    = 1'b0;
                if (req_n) begin
                    next_s.state     = CLS_CONFIG;
                    next_s.start_tgl = ~s.start_tgl;
                end
            end
            CLS_CONFIG: begin
                if ((s.first_sync ^ s.first_seen) && !s.dlock) begin
                    next_s.dlock    = 1'b1;
                    next_s.opt_init = lk.first[`CLS_OPT_INIT_OUT_BIT];
                    next_s.opt_auto = lk.first[`CLS_OPT_AUTORST_BIT];
                    next_s.opt_user = lk.first[`CLS_OPT_USERCLK_BIT];
                end
                if (s.err_sync[1]) begin
                    next_s.state = CLS_ERROR;
                    next_s.cnt   = 32'h0;
                end else if (full_evt) begin
                    next_s.state = CLS_INIT;
                    next_s.cnt   = 32'h0;
                end
            end
            CLS_ERROR: begin
                if (s.opt_auto && s.cnt >= 32'(RESTART_CYC - 1))
                    next_s.state = CLS_RESET;
            end
            CLS_INIT: begin
                if (s.opt_user ? udone_evt
                               : (s.cnt >= 32'(INIT_CYCLES - 1)))
                    next_s.state = CLS_USER;
            end
            CLS_USER: ;
            default: next_s.state = CLS_RESET;
        endcase
        if (s.state != CLS_POR && !req_n) begin
            next_s.state = CLS_RESET;
            next_s.cnt   = 32'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic status_low;
    logic done_low;
    logic init_low;

    assign status_low = (s.state == CLS_POR) || (s.state == CLS_RESET)
                      || (s.state == CLS_ERROR);
    assign done_low   = (s.state == CLS_POR) || (s.state == CLS_RESET)
                      || (s.state == CLS_CONFIG) || (s.state == CLS_ERROR);
    assign init_low   = s.opt_init && (s.state == CLS_CONFIG || s.state == CLS_INIT
                      || s.state == CLS_ERROR);

    assign pins.status_n.o  = 1'b0;
    assign pins.status_n.oe = status_low;
    assign pins.done.o      = 1'b0;
    assign pins.done.oe     = done_low;
    assign pins.init_out.o  = 1'b0;
    assign pins.init_out.oe = init_low;
    assign user_mode        = (s.state == CLS_USER);
    assign user_io_tristate = !user_mode;
    assign user_io_pullup   = (s.state != CLS_POR) && !user_mode;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_por_lines: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s.state == CLS_POR |-> pins.status_n.oe && pins.done.oe)
        else $error("lines not low in power-on reset");
    chk_req_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !req_n && s.state != CLS_POR |=> s.state == CLS_RESET)
        else $error("request low did not reset");
    chk_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s.state == CLS_RESET && req_n |=> !pins.status_n.oe || !req_n)
        else $error("status not released");
    chk_err_lines: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s.state == CLS_ERROR |-> pins.status_n.oe && pins.done.oe)
        else $error("error lines wrong");
    chk_restart_time: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s.state == CLS_ERROR && s.opt_auto && req_n
        |-> s.cnt < 32'(RESTART_CYC))
        else $error("restart too late");
    chk_init_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(user_mode) && !s.opt_user |-> $past(s.cnt) == 32'(INIT_CYCLES - 1))
        else $error("init count wrong");
    chk_done_user: assert property (@(posedge sys_clk) disable iff (sys_rst)
        user_mode |-> !pins.done.oe && !pins.status_n.oe && !pins.init_out.oe)
        else $error("lines held in user mode");
    chk_io_user: assert property (@(posedge sys_clk) disable iff (sys_rst)
        user_mode |-> !user_io_pullup && !user_io_tristate)
        else $error("user io not handed over");
endmodule

// File: pkg/cls_map.svh
`ifndef CLS_MAP_SVH
`define CLS_MAP_SVH
`define CLS_CLK_MHZ           25
`define CLS_POR_FAST_US       2
`define CLS_POR_STD_US        50
`define CLS_POR_FAST_CYC      (`CLS_POR_FAST_US * `CLS_CLK_MHZ)
`define CLS_POR_STD_CYC       (`CLS_POR_STD_US * `CLS_CLK_MHZ)
`define CLS_RESTART_US        230
`define CLS_RESTART_CYC       (`CLS_RESTART_US * `CLS_CLK_MHZ)
`define CLS_REQ_MIN_NS        500
`define CLS_INIT_CYCLES       3192
`define CLS_FRAME_BITS        32
`define CLS_OPT_INIT_OUT_BIT  0
`define CLS_OPT_AUTORST_BIT   1
`define CLS_OPT_USERCLK_BIT   2
`endif

// File: pkg/cls_pkg.sv
package cls_pkg;
    typedef enum logic [2:0] {
        CLS_POR    = 3'b000,
        CLS_RESET  = 3'b001,
        CLS_CONFIG = 3'b010,
        CLS_ERROR  = 3'b011,
        CLS_INIT   = 3'b100,
        CLS_USER   = 3'b101
    } cls_state_t;

    typedef enum logic [1:0] {
        CLS_SCH_AS  = 2'h0,
        CLS_SCH_AP  = 2'h1,
        CLS_SCH_PS  = 2'h2,
        CLS_SCH_FPP = 2'h3
    } cls_scheme_t;

    // open-drain pin: oe high pulls low
    typedef struct packed {
        logic o;
        logic oe;
    } cls_od_t;

    typedef struct packed {
        cls_od_t status_n;
        cls_od_t done;
        cls_od_t init_out;
    } cls_pins_t;
endpackage

// File: verification/cls_host_model.sv
`timescale 1ns/1ps
module cls_host_model (
    output logic       config_request_n,
    output logic       config_data_clock,
    output logic [7:0] config_data,
    output logic       frame_error,
    output logic       user_startup_clock
);
    initial begin
        config_request_n   = 1'b1;
        config_data_clock  = 1'b0;
        config_data        = 8'h5a;
        frame_error        = 1'b0;
        user_startup_clock = 1'b0;
    end
    task automatic pulse_request(input int ns);
        config_request_n = 1'b0;
        #(ns);
        config_request_n = 1'b1;
    endtask
    // link clock runs only within a frame; released data line flips
    task automatic send_words(input logic [7:0] w [$]);
        foreach (w[i]) begin
            config_data = w[i];
            #24 config_data_clock = 1'b1;
            #24 config_data_clock = 1'b0;
        end
        config_data = ~config_data;
    endtask
    task automatic user_clock(input int n);
        repeat (n) begin
            #30 user_startup_clock = 1'b1;
            #30 user_startup_clock = 1'b0;
        end
    endtask
endmodule

// File: verification/cls_sequencer_test.sv
`timescale 1ns/1ps
module cls_sequencer_test;
    import cls_pkg::*;
    logic             sys_clk;
    logic             sys_rst;
    logic [3:0]       scheme_select;
    logic             data_clk;
    logic             user_clk;
    logic             req_n;
    logic             frame_error;
    logic [7:0]       config_data;
    cls_pins_t        pins;
    logic             user_io_tristate;
    logic             user_io_pullup;
    logic             user_mode;
    int               err_count = 0;
    int               checks = 0;
    logic [31:0]      seed = 32'd37265;

    cls_host_model cls_host_model_inst (
        .config_request_n  (req_n),
        .config_data_clock (data_clk),
        .config_data       (config_data),
        .frame_error       (frame_error),
        .user_startup_clock(user_clk)
    );
    cls_sequencer #(.POR_STD_CYC(20), .RESTART_CYC(20), .INIT_CYCLES(10),
                    .IMAGE_WORDS(4)) cls_sequencer_inst (
        .sys_clk           (sys_clk),
        .sys_rst           (sys_rst),
        .config_data_clock (data_clk),
        .user_startup_clock(user_clk),
        .config_request_n  (req_n),
        .scheme_select     (scheme_select),
        .config_data       (config_data),
        .frame_error       (frame_error),
        .pins              (pins),
        .user_io_tristate  (user_io_tristate),
        .user_io_pullup    (user_io_pullup),
        .user_mode         (user_mode)
    );
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic sig(input int sel);
        case (sel)
            0: return pins.status_n.oe;
            1: return pins.done.oe;
            2: return pins.init_out.oe;
            default: return user_mode;
        endcase
    endfunction
    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wait_sig(input string what, input int sel, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(sel) !== v && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(what, v, sig(sel));
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic power_up(input logic [3:0] code);
        cycles(1);
        scheme_select = code;
        sys_rst = 1'b1;
        cycles(3);
        sys_rst = 1'b0;
    endtask
    // every word carries the option bits, so a word lost to the sync still configures
    task automatic load(input logic [2:0] opts, input int n);
        logic [7:0] q [$];
        repeat (n) begin
            seed = xorshift(seed);
            q.push_back({seed[7:3], opts});
        end
        cls_host_model_inst.send_words(q);
    endtask
    task automatic frame_fault(input logic [2:0] opts);
        load(opts, 4);
        cycles(4);
        cls_host_model_inst.frame_error = 1'b1;
        wait_sig("status low", 0, 1'b1, 10);
        chk("done low", 1'b1, pins.done.oe);
        cls_host_model_inst.frame_error = 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        $display("mismatch watchdog expected finish seen hang");
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        scheme_select = 4'h0;
        power_up(4'hd);
        chk("por status", 1'b1, pins.status_n.oe);
        chk("por done", 1'b1, pins.done.oe);
        chk("por tristate", 1'b1, user_io_tristate);
        cycles(44);
        chk("fast por length", 1'b1, pins.status_n.oe);
        wait_sig("fast por end", 0, 1'b0, 20);
        chk("pullup", 1'b1, user_io_pullup);
        chk("tristate", 1'b1, user_io_tristate);
        power_up(4'h0);
        wait_sig("std por end", 0, 1'b0, 30);
        $display("test power_up done");
        chk("init out idle", 1'b0, pins.init_out.oe);
        fork
            load(3'b001, 8);
            begin
                wait_sig("init out low", 2, 1'b1, 30);
                wait_sig("done release", 1, 1'b0, 40);
                cycles(7);
                chk("init count", 1'b0, user_mode);
                wait_sig("user mode", 3, 1'b1, 8);
            end
        join
        chk("init out release", 1'b0, pins.init_out.oe);
        chk("user pullup", 1'b0, user_io_pullup);
        chk("user tristate", 1'b0, user_io_tristate);
        $display("test load done");
        fork
            cls_host_model_inst.pulse_request(520);
            begin
                cycles(6);
                chk("reconf status", 1'b1, pins.status_n.oe);
                chk("reconf done", 1'b1, pins.done.oe);
                chk("reconf tristate", 1'b1, user_io_tristate);
                chk("reconf user", 1'b0, user_mode);
            end
        join
        wait_sig("reconf start", 0, 1'b0, 10);
        $display("test reconfigure done");
        frame_fault(3'b000);
        cycles(40);
        chk("no auto restart", 1'b1, pins.status_n.oe);
        cls_host_model_inst.pulse_request(520);
        wait_sig("host restart", 0, 1'b0, 30);
        frame_fault(3'b010);
        wait_sig("auto restart", 0, 1'b0, 40);
        $display("test error done");
        load(3'b100, 8);
        wait_sig("done release", 1, 1'b0, 40);
        cycles(30);
        chk("user clock wait", 1'b0, user_mode);
        cls_host_model_inst.user_clock(14);
        wait_sig("user clock init", 3, 1'b1, 10);
        $display("test user clock done");
        wrap_up();
    end
endmodule
